// *** verification/tb_top.sv ***
// self-checking bench for the time value register block
`default_nettype none
`include "time_value_cfg.svh"
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin fails++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import time_value_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic tick_load_i = 1'b0;
   wkdy_hours_t tick_wh_i = '0;
   min_sec_t tick_ms_i = '0;
   wkdy_hours_t wh_o;
   min_sec_t ms_o;
   logic clock_write_unlock_o;
   logic fields_legal_o;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] r;
   // bit 16 holds the expected legality of the word below it
   localparam logic [16:0] WH_TAB [0:5] = '{17'h1_0629, 17'h0_0700, 17'h0_0030, 17'h0_000A, 17'h0_FFFF,
                                            17'h1_0000};
   localparam logic [16:0] MS_TAB [0:5] = '{17'h1_5959, 17'h0_6000, 17'h0_0A00, 17'h0_0060, 17'h0_000A,
                                            17'h0_FFFF};

   // 100 ns clock
   always #50 clk_i = ~clk_i;

   time_value_regs dut (
      .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .tick_load_i(tick_load_i),
      .tick_wh_i(tick_wh_i), .tick_ms_i(tick_ms_i), .wh_o(wh_o), .ms_o(ms_o),
      .clock_write_unlock_o(clock_write_unlock_o), .fields_legal_o(fields_legal_o)
   );

   // ----------------------------------------
   // bus access and closing
   // ----------------------------------------
   // one access; request held until waitrequest samples low
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] rd);
      @(posedge clk_i);
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(1'b1, a, d, 4'h3, dummy);
   endtask
   task automatic rd(input logic [3:0] a);
      xfer(1'b0, a, 32'h0, 4'hF, r);
   endtask

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // write while locked straight after reset must be dropped and flagged
   task automatic t_locked();
      wr(`WKDY_HOURS_OFS, 32'h0123);
      rd(`WKDY_HOURS_OFS);
      `CHK(r[15:0], 16'h0000)
      `CHK(wh_o, wkdy_hours_t'(9'h000))
      rd(`STATUS_OFS);
      `CHK(r[1], 1'b1)
      rd(`STATUS_OFS);
      `CHK(r[1], 1'b0)
   endtask

   // unlocked: every digit boundary, packing and the dead bits
   task automatic t_wh_fields();
      wr(`UNLOCK_OFS, 32'h1);
      for (int i = 0; i < 6; i++) begin
         wr(`WKDY_HOURS_OFS, {16'hFFFF, WH_TAB[i][15:0]});
         rd(`WKDY_HOURS_OFS);
         `CHK(r[15:0], WH_TAB[i][15:0] & `WKDY_HOURS_MASK)
         `CHK(wh_o, wkdy_hours_t'({WH_TAB[i][10:8], WH_TAB[i][5:4], WH_TAB[i][3:0]}))
         `CHK(fields_legal_o, WH_TAB[i][16])
      end
      wr(`WKDY_HOURS_OFS, 32'h0523);
   endtask

   // minutes/seconds need no unlock; a relocked hours write is dropped
   task automatic t_ms_fields();
      wr(`UNLOCK_OFS, 32'h0);
      @(negedge clk_i);
      `CHK(clock_write_unlock_o, 1'b0)
      for (int i = 0; i < 6; i++) begin
         wr(`MIN_SEC_OFS, {16'hFFFF, MS_TAB[i][15:0]});
         rd(`MIN_SEC_OFS);
         `CHK(r[15:0], MS_TAB[i][15:0] & `MIN_SEC_MASK)
         `CHK(ms_o, min_sec_t'({MS_TAB[i][14:12], MS_TAB[i][11:8], MS_TAB[i][6:4], MS_TAB[i][3:0]}))
         `CHK(fields_legal_o, MS_TAB[i][16])
      end
      wr(`WKDY_HOURS_OFS, 32'h0000);
      rd(`WKDY_HOURS_OFS);
      `CHK(r[15:0], 16'h0523)
   endtask

   // byte lanes, unmapped space and increment load
   task automatic t_lanes_tick();
      wr(`MIN_SEC_OFS, 32'h5959);
      xfer(1'b1, `MIN_SEC_OFS, 32'h0, 4'h2, r);
      rd(`MIN_SEC_OFS);
      `CHK(r[15:0], 16'h0059)
      rd(4'h2);
      `CHK(r, 32'h0)
      @(posedge clk_i);
      tick_wh_i <= wkdy_hours_t'({3'h4, 2'h1, 4'h7});
      tick_ms_i <= min_sec_t'({3'h3, 4'h8, 3'h2, 4'h6});
      tick_load_i <= 1'b1;
      @(posedge clk_i);
      tick_load_i <= 1'b0;
      rd(`MIN_SEC_OFS);
      `CHK(r[15:0], 16'h3826)
      rd(`WKDY_HOURS_OFS);
      `CHK(r[15:0], 16'h0417)
   endtask

   // ----------------------------------------
   // main sequence and hang guard
   // ----------------------------------------
   // a full run needs under 1000 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 3000) begin
         fails++;
         stop_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      t_locked();
      t_wh_fields();
      t_ms_fields();
      t_lanes_tick();
      stop_test();
   end
endmodule
`default_nettype wire

// *** verilog/bcd_digit_check.sv ***
// legality check for one bcd digit against its upper limit
`default_nettype none
module bcd_digit_check #(
   parameter int W = 4
) (
   input wire logic [W-1:0] digit_i,
   input wire logic [W-1:0] max_i,
   output logic ok_o
);
   // a digit is legal when it does not pass its limit
   assign ok_o = (digit_i <= max_i);
endmodule
`default_nettype wire

// *** verilog/time_pack.sv ***
// packing of time fields into register words
`default_nettype none
`include "time_value_cfg.svh"
module time_pack (
   input wire time_value_pkg::wkdy_hours_t wh_i,
   input wire time_value_pkg::min_sec_t ms_i,
   output logic [15:0] wh_word_o,
   output logic [15:0] ms_word_o
);
   import time_value_pkg::*;
   // unused bit positions are forced to zero by construction
   assign wh_word_o = {5'h00, wh_i.weekday_digit, 2'h0, wh_i.hour_tens_digit, wh_i.hour_ones_digit};
   assign ms_word_o = {1'h0, ms_i.minute_tens_digit, ms_i.minute_ones_digit,
                       1'h0, ms_i.second_tens_digit, ms_i.second_ones_digit};
endmodule
`default_nettype wire

// *** verilog/time_value_cfg.svh ***
// constants for the time value register block
`ifndef TIME_VALUE_CFG_SVH
`define TIME_VALUE_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WKDY_HOURS_OFS 4'h0
`define MIN_SEC_OFS 4'h4
`define UNLOCK_OFS 4'h8
`define STATUS_OFS 4'hC
// ----------------------------------------
// field positions
// ----------------------------------------
`define WEEKDAY_LSB 8
`define HOUR_TENS_LSB 4
`define MINUTE_TENS_LSB 12
`define MINUTE_ONES_LSB 8
`define SECOND_TENS_LSB 4
`define DIGIT_LSB 0
// ----------------------------------------
// field limits and reset values
// ----------------------------------------
`define WEEKDAY_MAX 3'h6
`define HOUR_TENS_MAX 2'h2
`define TEN6_MAX 3'h5
`define ONES_MAX 4'h9
`define WKDY_HOURS_MASK 16'h073F
`define MIN_SEC_MASK 16'h7F7F
`define WKDY_HOURS_RESET 9'h000
`define MIN_SEC_RESET 14'h0000
`define UNLOCK_RESET 1'h0
`endif

// *** verilog/time_value_pkg.sv ***
// types for the time value register block
`default_nettype none
package time_value_pkg;
   // weekday and hours fields
   typedef struct packed {
      logic [2:0] weekday_digit;
      logic [1:0] hour_tens_digit;
      logic [3:0] hour_ones_digit;
   } wkdy_hours_t;
   // minutes and seconds fields
   typedef struct packed {
      logic [2:0] minute_tens_digit;
      logic [3:0] minute_ones_digit;
      logic [2:0] second_tens_digit;
      logic [3:0] second_ones_digit;
   } min_sec_t;
   // bus request bundle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } bus_req_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_t;
endpackage
`default_nettype wire

// *** verilog/time_value_regs.sv ***
// time of day value registers with avalon-mm slave
//
// How it works
// - weekday digit sits in bits 10 to 8, values zero to six.
// - hour tens digit sits in bits 5 to 4, values zero to two.
// - hour ones digit sits in bits 3 to 0, values zero to nine.
// - weekday/hour writes land only while the write unlock bit is one.
// - minute tens digit sits in bits 14 to 12, values zero to five.
// - minute ones digit sits in bits 11 to 8, values zero to nine.
// - second tens digit sits in bits 6 to 4, values zero to five.
// - second ones digit sits in bits 3 to 0, values zero to nine.
// - unimplemented bits read zero and ignore writes.
`default_nettype none
`include "time_value_cfg.svh"
module time_value_regs (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic tick_load_i,
   input wire time_value_pkg::wkdy_hours_t tick_wh_i,
   input wire time_value_pkg::min_sec_t tick_ms_i,
   output time_value_pkg::wkdy_hours_t wh_o,
   output time_value_pkg::min_sec_t ms_o,
   output logic clock_write_unlock_o,
   output logic fields_legal_o
);
   import time_value_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   wkdy_hours_t wh_q;
   min_sec_t ms_q;
   logic unlock_q;
   logic refused_q;
   bus_state_t st_q;
   logic [31:0] rdata_q;
   bus_req_t req;
   logic [15:0] wh_word;
   logic [15:0] ms_word;
   logic [15:0] wh_new;
   logic [15:0] ms_new;
   logic take;
   logic wr_wh;
   logic wr_ms;
   logic wr_unlock;
   logic [6:0] ok;

   // byte lane merge; lanes not enabled keep old bits
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   assign req = '{rd: avs_read_i, wr: avs_write_i, addr: avs_address_i,
                  wdata: avs_writedata_i, be: avs_byteenable_i};

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   // one wait cycle per access; read data still comes through the read mux combinationally in the ack cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q <= BUS_IDLE;
      end else begin
         case (st_q)
            BUS_IDLE: if (req.rd || req.wr) st_q <= BUS_ACK;
            BUS_ACK: st_q <= BUS_IDLE;
            default: st_q <= BUS_IDLE;
         endcase
      end
   end
   // waitrequest falls in the ack state; decode relies on the master holding its request
   assign avs_waitrequest_o = (req.rd || req.wr) && (st_q != BUS_ACK);
   assign take = (st_q == BUS_ACK) && (req.rd || req.wr);
   assign wr_wh = take && req.wr && (req.addr == `WKDY_HOURS_OFS);
   assign wr_ms = take && req.wr && (req.addr == `MIN_SEC_OFS);
   assign wr_unlock = take && req.wr && (req.addr == `UNLOCK_OFS) && req.be[0];

   time_pack packer (
      .wh_i(wh_q),
      .ms_i(ms_q),
      .wh_word_o(wh_word),
      .ms_word_o(ms_word)
   );

   // masks drop writes to unused positions
   assign wh_new = merge(wh_word, req.wdata, req.be) & `WKDY_HOURS_MASK;
   assign ms_new = merge(ms_word, req.wdata, req.be) & `MIN_SEC_MASK;

   // ----------------------------------------
   // write unlock bit
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         unlock_q <= `UNLOCK_RESET;
      end else if (wr_unlock) begin
         unlock_q <= req.wdata[0];
      end
   end

   // ----------------------------------------
   // weekday and hours register
   // ----------------------------------------
   // an unlocked bus write wins over the increment load in the same cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wh_q <= wkdy_hours_t'(`WKDY_HOURS_RESET);
      end else if (wr_wh && unlock_q) begin
         wh_q.weekday_digit <= wh_new[`WEEKDAY_LSB +: 3];
         wh_q.hour_tens_digit <= wh_new[`HOUR_TENS_LSB +: 2];
         wh_q.hour_ones_digit <= wh_new[`DIGIT_LSB +: 4];
      end else if (tick_load_i) begin
         wh_q <= tick_wh_i;
      end
   end

   // sticky marker of a refused write, cleared by reading status
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         refused_q <= 1'b0;
      end else if (wr_wh && !unlock_q) begin
         refused_q <= 1'b1;
      end else if (take && req.rd && req.addr == `STATUS_OFS) begin
         refused_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // minutes and seconds register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ms_q <= min_sec_t'(`MIN_SEC_RESET);
      end else if (wr_ms) begin
         ms_q.minute_tens_digit <= ms_new[`MINUTE_TENS_LSB +: 3];
         ms_q.minute_ones_digit <= ms_new[`MINUTE_ONES_LSB +: 4];
         ms_q.second_tens_digit <= ms_new[`SECOND_TENS_LSB +: 3];
         ms_q.second_ones_digit <= ms_new[`DIGIT_LSB +: 4];
      end else if (tick_load_i) begin
         ms_q <= tick_ms_i;
      end
   end

   // ----------------------------------------
   // digit range checks
   // ----------------------------------------
   // software may store an illegal digit; the flag reports it, no clamp
   bcd_digit_check #(.W(3)) chk_weekday (.digit_i(wh_q.weekday_digit), .max_i(`WEEKDAY_MAX), .ok_o(ok[0]));
   bcd_digit_check #(.W(2)) chk_hten (.digit_i(wh_q.hour_tens_digit), .max_i(`HOUR_TENS_MAX), .ok_o(ok[1]));
   bcd_digit_check #(.W(4)) chk_hone (.digit_i(wh_q.hour_ones_digit), .max_i(`ONES_MAX), .ok_o(ok[2]));
   bcd_digit_check #(.W(3)) chk_mten (.digit_i(ms_q.minute_tens_digit), .max_i(`TEN6_MAX), .ok_o(ok[3]));
   bcd_digit_check #(.W(4)) chk_mone (.digit_i(ms_q.minute_ones_digit), .max_i(`ONES_MAX), .ok_o(ok[4]));
   bcd_digit_check #(.W(3)) chk_sten (.digit_i(ms_q.second_tens_digit), .max_i(`TEN6_MAX), .ok_o(ok[5]));
   bcd_digit_check #(.W(4)) chk_sone (.digit_i(ms_q.second_ones_digit), .max_i(`ONES_MAX), .ok_o(ok[6]));

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (take && req.rd) begin
         case (req.addr)
            `WKDY_HOURS_OFS: rdata_q <= {16'h0000, wh_word};
            `MIN_SEC_OFS: rdata_q <= {16'h0000, ms_word};
            `UNLOCK_OFS: rdata_q <= {31'h0, unlock_q};
            `STATUS_OFS: rdata_q <= {30'h0, refused_q, &ok};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   // read data is presented combinationally at the accepting edge
   always_comb begin
      avs_readdata_o = 32'h0000_0000;
      if (take && req.rd) begin
         case (req.addr)
            `WKDY_HOURS_OFS: avs_readdata_o = {16'h0000, wh_word};
            `MIN_SEC_OFS: avs_readdata_o = {16'h0000, ms_word};
            `UNLOCK_OFS: avs_readdata_o = {31'h0, unlock_q};
            `STATUS_OFS: avs_readdata_o = {30'h0, refused_q, &ok};
            default: avs_readdata_o = 32'h0000_0000;
         endcase
      end else begin
         avs_readdata_o = rdata_q;
      end
   end

   // wh_o, ms_o and the unlock output come straight from the registers; fields_legal_o is decoded from them by the digit checks
   assign wh_o = wh_q;
   assign ms_o = ms_q;
   assign clock_write_unlock_o = unlock_q;
   assign fields_legal_o = &ok;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // each bus event is named once so the properties read as cause and effect
   sequence locked_wh_write_s;
      wr_wh && !unlock_q && !tick_load_i;
   endsequence

   sequence unlocked_wh_write_s;
      wr_wh && unlock_q;
   endsequence

   sequence ms_write_s;
      wr_ms;
   endsequence

   sequence unlock_write_s;
      wr_unlock;
   endsequence

   sequence status_read_s;
      take && req.rd && (req.addr == `STATUS_OFS);
   endsequence

   // a tick that no bus write overrides
   sequence plain_tick_s;
      tick_load_i && !wr_wh && !wr_ms;
   endsequence

   sequence request_open_s;
      (st_q == BUS_IDLE) && (req.rd || req.wr);
   endsequence

   sequence accepted_read_s;
      take && req.rd;
   endsequence

   // weekday and hours write gate
   locked_write_held_a: assert property (@(posedge clk_i) disable iff (srst_i)
      locked_wh_write_s |=> $stable(wh_q))
      else $error("locked weekday/hour write changed the register");

   unlocked_write_lands_a: assert property (@(posedge clk_i) disable iff (srst_i)
      unlocked_wh_write_s |=> (wh_word == $past(wh_new)))
      else $error("unlocked weekday/hour write did not land");

   locked_read_same_a: assert property (@(posedge clk_i) disable iff (srst_i)
      locked_wh_write_s |=> refused_q && (wh_word == $past(wh_word)))
      else $error("locked write altered contents or missed flag");

   // refused write marker
   flag_sticky_a: assert property (@(posedge clk_i) disable iff (srst_i)
      refused_q && !(take && req.rd && (req.addr == `STATUS_OFS)) |=> refused_q)
      else $error("refused write marker dropped without a status read");

   flag_cleared_a: assert property (@(posedge clk_i) disable iff (srst_i)
      status_read_s |=> !refused_q)
      else $error("status read did not clear the refused write marker");

   // unlock bit
   unlock_lands_a: assert property (@(posedge clk_i) disable iff (srst_i)
      unlock_write_s |=> (unlock_q == $past(req.wdata[0])))
      else $error("unlock write did not land");

   unlock_held_a: assert property (@(posedge clk_i) disable iff (srst_i)
      !wr_unlock |=> $stable(unlock_q))
      else $error("unlock bit changed without a write");

   // unused positions
   wh_zero_bits_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wh_word & ~`WKDY_HOURS_MASK) == 16'h0000)
      else $error("unused weekday/hour bits not zero");

   ms_zero_bits_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (ms_word & ~`MIN_SEC_MASK) == 16'h0000)
      else $error("unused minutes/seconds bits not zero");

   upper_half_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
      accepted_read_s |-> (avs_readdata_o[31:16] == 16'h0000))
      else $error("upper half of read data not zero");

   // field placement
   weekday_digit_field_a: assert property (@(posedge clk_i) disable iff (srst_i)
      unlocked_wh_write_s |=> wh_q.weekday_digit == $past(wh_new[10:8]))
      else $error("weekday digit not taken from bits 10 to 8");

   hour_fields_a: assert property (@(posedge clk_i) disable iff (srst_i)
      unlocked_wh_write_s |=> {wh_q.hour_tens_digit, wh_q.hour_ones_digit} == $past(wh_new[5:0]))
      else $error("hour digits not taken from bits 5 to 0");

   min_fields_a: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_ms |=> {ms_q.minute_tens_digit, ms_q.minute_ones_digit} == $past(ms_new[14:8]))
      else $error("minute digits not taken from bits 14 to 8");

   sec_fields_a: assert property (@(posedge clk_i) disable iff (srst_i)
      wr_ms |=> {ms_q.second_tens_digit, ms_q.second_ones_digit} == $past(ms_new[6:0]))
      else $error("second digits not taken from bits 6 to 0");

   ms_write_lands_a: assert property (@(posedge clk_i) disable iff (srst_i)
      ms_write_s |=> (ms_word == $past(ms_new)))
      else $error("minutes/seconds write did not land");

   // digit ranges: an illegal digit must pull the legality flag down
   wh_range_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (wh_q.weekday_digit > `WEEKDAY_MAX) || (wh_q.hour_tens_digit > `HOUR_TENS_MAX) ||
      (wh_q.hour_ones_digit > `ONES_MAX) |-> !fields_legal_o)
      else $error("illegal weekday/hour digit reported as legal");

   ms_range_a: assert property (@(posedge clk_i) disable iff (srst_i)
      (ms_q.minute_tens_digit > `TEN6_MAX) || (ms_q.minute_ones_digit > `ONES_MAX) ||
      (ms_q.second_tens_digit > `TEN6_MAX) || (ms_q.second_ones_digit > `ONES_MAX) |-> !fields_legal_o)
      else $error("illegal minutes/seconds digit reported as legal");

   // increment load
   tick_loads_a: assert property (@(posedge clk_i) disable iff (srst_i)
      plain_tick_s |=> (wh_q == $past(tick_wh_i)) && (ms_q == $past(tick_ms_i)))
      else $error("increment load did not reach the registers");

   // bus handshake and read data
   bus_answer_a: assert property (@(posedge clk_i) disable iff (srst_i)
      request_open_s |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("access not answered after one wait cycle");

   idle_no_wait_a: assert property (@(posedge clk_i) disable iff (srst_i)
      !(req.rd || req.wr) |-> !avs_waitrequest_o)
      else $error("waitrequest high with no request");

   readdata_kept_a: assert property (@(posedge clk_i) disable iff (srst_i)
      accepted_read_s |=> (avs_readdata_o == $past(avs_readdata_o)))
      else $error("read data not kept after the accepting cycle");

   readdata_stands_a: assert property (@(posedge clk_i) disable iff (srst_i)
      !(take && req.rd) ##1 !(take && req.rd) |-> $stable(avs_readdata_o))
      else $error("read data changed without a read");

   wh_read_word_a: assert property (@(posedge clk_i) disable iff (srst_i)
      take && req.rd && (req.addr == `WKDY_HOURS_OFS) |-> (avs_readdata_o[15:0] == wh_word))
      else $error("weekday/hour read returned the wrong word");

   ms_read_word_a: assert property (@(posedge clk_i) disable iff (srst_i)
      take && req.rd && (req.addr == `MIN_SEC_OFS) |-> (avs_readdata_o[15:0] == ms_word))
      else $error("minutes/seconds read returned the wrong word");

   unmapped_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
      take && req.rd && (req.addr[1:0] != 2'h0) |-> (avs_readdata_o == 32'h0000_0000))
      else $error("unmapped read not zero");

   unmapped_write_inert_a: assert property (@(posedge clk_i) disable iff (srst_i)
      take && req.wr && (req.addr[1:0] != 2'h0) && !tick_load_i |=> $stable(wh_q) && $stable(ms_q) && $stable(unlock_q))
      else $error("unmapped write changed a register");
endmodule
`default_nettype wire
